/* adcc_pkg.sv */
// adcc_pkg: constants, pin positions and state codes of the converter control block
// assumes a 100 MHz system clock; the acquisition and conversion counts derive from that rate
package adcc_pkg;

    // result word and buffer
    localparam int RES_W     = 16;              // conversion result width
    localparam int BUF_DEPTH = 2;               // results held between core and port

    // clock and timing
    localparam int CLK_NS    = 10;              // system clock period in ns
    localparam int T_ACQ_NS  = 1800;            // least acquisition time, ns
    localparam int T_CONV_NS = 8000;            // conversion time, ns
    localparam int ACQ_CYC   = (T_ACQ_NS + CLK_NS - 1) / CLK_NS;   // rounded up
    localparam int CONV_CYC  = T_CONV_NS / CLK_NS;                 // whole cycles
    localparam logic [15:0] ACQ_LAST  = 16'(ACQ_CYC - 1);
    localparam logic [15:0] CONV_LAST = 16'(CONV_CYC - 1);

    // internal serial clock: one bit is four quarters of this many cycles
    localparam int SCLK_QTR = 2;
    localparam logic [3:0] QTR_LAST = 4'(SCLK_QTR - 1);
    localparam logic [3:0] BIT_LAST = 4'hF;     // last of sixteen serial bits

    // positions on the shared data pins
    localparam int PIN_SERIAL_RESULT_OUT = 8;               // serial_result_out
    localparam int PIN_SCLK  = 9;               // serial clock in or out
    localparam int PIN_MARK  = 10;              // frame marker / bit 10
    localparam int PIN_RDERR = 11;              // incomplete_read_flag / bit 11
    localparam int PIN_TOP   = 12;              // lowest pin that carries its own result bit in both modes

    // positions in the synchronised input vector
    localparam int SY_RST  = 0;
    localparam int SY_PD   = 1;
    localparam int SY_CNV  = 2;
    localparam int SY_CS   = 3;
    localparam int SY_RD   = 4;
    localparam int SY_SCLK = 5;
    localparam int SY_SER  = 6;
    localparam int SY_EXT  = 7;
    localparam int SY_INV  = 8;
    localparam int SY_RREF = 9;
    localparam int SY_RBUF = 10;
    localparam int SY_W    = 11;
    // idle levels: strobes and convert start high, the rest low
    localparam logic [SY_W-1:0] SYNC_RST = 11'h01C;
    localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;

    // conversion sequencer states
    typedef enum logic [2:0] {
        ST_ACQ   = 3'h1,                        // tracking, acquisition timer runs
        ST_ARMED = 3'h2,                        // acquired, waiting for a start edge
        ST_CONV  = 3'h4                         // holding and converting
    } adcc_state_e;

endpackage

/* adcc_stream_if.sv */
// adcc_stream_if: valid/ready word channel between the block's own modules
// assumes both ends share one clock
interface adcc_stream_if #(parameter int W = 16);
    logic         valid;                        // word offered
    logic         ready;                        // word can be taken
    logic [W-1:0] data;                         // the word
    modport prod (output valid, output data, input ready);
    modport cons (input valid, input data, output ready);
endinterface

/* adcc_buf.sv */
// adcc_buf: small flip-flop fifo with valid and ready on both sides
// assumes one clock; clr_i empties it in one cycle
module adcc_buf #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    // clock, reset, enable
    input  wire logic      clk_i,
    input  wire logic      arst_n_i,
    input  wire logic      ce_i,
    input  wire logic      clr_i,
    // channels
    adcc_stream_if.cons    in_s,
    adcc_stream_if.prod    out_s
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_q [DEPTH];               // storage, indexed by pointer
    logic [W-1:0]  mem_d [DEPTH];
    logic [AW-1:0] wp_q, wp_d;                  // write pointer
    logic [AW-1:0] rp_q, rp_d;                  // read pointer
    logic [CW-1:0] n_q, n_d;                    // words held
    logic          push, pop;

    // pointer step with wrap at the depth
    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // honest full and empty
    assign in_s.ready  = (n_q != CW'(DEPTH));
    assign out_s.valid = (n_q != '0);
    assign out_s.data  = mem_q[rp_q];
    assign push        = in_s.valid & in_s.ready;
    assign pop         = out_s.valid & out_s.ready;

    // next pointers, count and storage
    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        n_d   = n_q + CW'(push) - CW'(pop);
        if (push) begin
            mem_d[wp_q] = in_s.data;
            wp_d        = nxt(wp_q);
        end
        if (pop) begin
            rp_d = nxt(rp_q);
        end
        if (clr_i) begin
            wp_d = '0;
            rp_d = '0;
            n_d  = '0;
        end
    end

    // registers only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mem_q <= '{default: '0};
            wp_q  <= '0;
            rp_q  <= '0;
            n_q   <= '0;
        end else if (ce_i) begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            n_q   <= n_d;
        end
    end
endmodule

/* adcc_top.sv */
// adcc_top: conversion sequencing and result output pins of a sampling converter
// assumes pins are asynchronous to CLK_SYS_I and the analog core holds
// SAR_RESULT_I steady on the last conversion cycle
module adcc_top #(
    parameter int BUF_DEPTH = adcc_pkg::BUF_DEPTH
) (
    // clock, reset, enable
    input  wire logic                       CLK_SYS_I,
    input  wire logic                       ARST_N_I,
    input  wire logic                       CE_I,
    // converter control pins
    input  wire logic                       RESET_I,
    input  wire logic                       POWER_DOWN_REQ_I,
    input  wire logic                       CONVERT_START_N_I,
    // read strobes
    input  wire logic                       CS_N_I,
    input  wire logic                       RD_N_I,
    // mode straps
    input  wire logic                       SERIAL_PARALLEL_SELECT_I,
    input  wire logic                       CLOCK_SOURCE_SELECT_I,
    input  wire logic                       FRAME_MARKER_INVERT_I,
    // reference control
    input  wire logic                       INTERNAL_REF_OFF_I,
    input  wire logic                       REF_BUFFER_OFF_I,
    // analog core
    input  wire logic [adcc_pkg::RES_W-1:0] SAR_RESULT_I,
    output logic                            HOLD_O,
    output logic                            LOW_POWER_O,
    output logic                            REF_EN_O,
    output logic                            REF_BUF_EN_O,
    // status
    output logic                            BUSY_O,
    // data pins; pin 9 doubles as serial clock input
    input  wire logic                       SCLK_PIN_I,
    output logic [adcc_pkg::RES_W-1:0]      DATA_O,
    output logic [adcc_pkg::RES_W-1:0]      DATA_OE_N_O
);
    import adcc_pkg::*;

    // ---------------- pin synchronisers ----------------
    logic [SY_W-1:0] pin_raw;                   // raw asynchronous inputs
    logic [SY_W-1:0] s1_q, s2_q, s3_q;          // three-stage chain
    logic [SY_W-1:0] f_q, f_d;                  // accepted levels
    logic            cnv_prev_q, sclk_prev_q;   // for edge finding

    assign pin_raw = {REF_BUFFER_OFF_I, INTERNAL_REF_OFF_I, FRAME_MARKER_INVERT_I,
                      CLOCK_SOURCE_SELECT_I, SERIAL_PARALLEL_SELECT_I, SCLK_PIN_I,
                      RD_N_I, CS_N_I, CONVERT_START_N_I, POWER_DOWN_REQ_I, RESET_I};

    // a change counts only once stages two and three agree
    always_comb begin
        f_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
    end

    // chain registers; s1 feeds only s2
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s1_q        <= SYNC_RST;
            s2_q        <= SYNC_RST;
            s3_q        <= SYNC_RST;
            f_q         <= SYNC_RST;
            cnv_prev_q  <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else if (CE_I) begin
            s1_q        <= pin_raw;
            s2_q        <= s1_q;
            s3_q        <= s2_q;
            f_q         <= f_d;
            cnv_prev_q  <= f_q[SY_CNV];
            sclk_prev_q <= f_q[SY_SCLK];
        end
    end

    // filtered levels by name
    logic rst_f, pd_f, cnv_f, cs_f, rd_f, sclk_f, ser_f, ext_f, inv_f;
    assign rst_f  = f_q[SY_RST];
    assign pd_f   = f_q[SY_PD];
    assign cnv_f  = f_q[SY_CNV];
    assign cs_f   = f_q[SY_CS];
    assign rd_f   = f_q[SY_RD];
    assign sclk_f = f_q[SY_SCLK];
    assign ser_f  = f_q[SY_SER];
    assign ext_f  = f_q[SY_EXT];
    assign inv_f  = f_q[SY_INV];

    // reference enables are the synchronised, filtered off levels, inverted
    assign REF_EN_O     = ~f_q[SY_RREF];
    assign REF_BUF_EN_O = ~f_q[SY_RBUF];

    // ---------------- result buffer ----------------
    adcc_stream_if #(.W(RES_W)) in_if ();
    adcc_stream_if #(.W(RES_W)) out_if ();

    adcc_buf #(.W(RES_W), .DEPTH(BUF_DEPTH)) u_buf (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .ce_i     (CE_I),
        .clr_i    (rst_f),
        .in_s     (in_if.cons),
        .out_s    (out_if.prod)
    );

    // ---------------- conversion sequencer ----------------
    adcc_state_e state_q, state_d;              // sequencer state
    logic [15:0] cnt_q, cnt_d;                  // acquisition / conversion timer
    logic        busy_q, busy_d;                // busy pin register
    logic        conv_done;                     // last conversion cycle
    logic        go_ok;                         // start allowed now
    logic        cnv_fall;                      // convert start fell

    assign conv_done = (state_q == ST_CONV) && (cnt_q == CONV_LAST);
    // power-down and a full buffer both hold off the next start;
    // gating at start means a finished result never meets a full buffer
    assign go_ok     = !pd_f && in_if.ready;
    assign cnv_fall  = cnv_prev_q && !cnv_f;

    // result goes to the buffer on the last conversion cycle
    assign in_if.valid = conv_done && !rst_f;
    assign in_if.data  = SAR_RESULT_I;

    // next state and timer
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 16'h0001;
        if (rst_f) begin
            state_d = ST_ACQ;
            cnt_d   = '0;
        end else begin
            unique case (state_q)
                ST_ACQ: begin
                    if (cnt_q == ACQ_LAST) begin
                        cnt_d = '0;
                        if (!cnv_f && go_ok) begin
                            state_d = ST_CONV;
                        end else begin
                            state_d = ST_ARMED;
                        end
                    end
                end
                ST_ARMED: begin
                    cnt_d = '0;
                    if (cnv_fall && go_ok) begin
                        state_d = ST_CONV;
                    end
                end
                ST_CONV: begin
                    // power-down never cuts a conversion short
                    if (conv_done) begin
                        state_d = ST_ACQ;
                        cnt_d   = '0;
                    end
                end
            endcase
        end
        busy_d = (state_d == ST_CONV);
    end

    // sequencer registers
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_q <= ST_ACQ;
            cnt_q   <= '0;
            busy_q  <= 1'b0;
        end else if (CE_I) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            busy_q  <= busy_d;
        end
    end

    assign BUSY_O      = busy_q;                // fall marks result ready, except when reset aborts a conversion
    assign HOLD_O      = (state_q == ST_CONV);
    assign LOW_POWER_O = pd_f && (state_q != ST_CONV);

    // ---------------- output port ----------------
    logic [RES_W-1:0] res_q, res_d;             // latched word for parallel reads
    logic [RES_W-1:0] sh_q, sh_d;               // serial shift register
    logic             loaded_q, loaded_d;       // unread word present
    logic             act_q, act_d;             // serial frame in progress
    logic [3:0]       bit_q, bit_d;             // bits already shifted
    logic [3:0]       div_q, div_d;             // quarter-bit divider
    logic [1:0]       ph_q, ph_d;               // quarter within a bit
    logic             sclk_q, sclk_d;           // internal serial clock
    logic             err_q, err_d;             // incomplete read pulse
    logic [RES_W-1:0] dout_q, dout_d;           // pin data register
    logic             en, pop, ext_edge;

    assign en  = !cs_f && !rd_f;
    // only take a new word while no frame is shifting
    assign out_if.ready = !act_q;
    assign pop = out_if.valid && !act_q;
    // external clock edges count only with select low
    assign ext_edge = ser_f && ext_f && !cs_f && sclk_f && !sclk_prev_q;

    // next shift, frame and pin values
    always_comb begin
        res_d    = res_q;
        sh_d     = sh_q;
        loaded_d = loaded_q;
        act_d    = act_q;
        bit_d    = bit_q;
        div_d    = div_q;
        ph_d     = ph_q;
        sclk_d   = sclk_q;
        err_d    = 1'b0;
        if (rst_f) begin
            act_d    = 1'b0;
            loaded_d = 1'b0;
            bit_d    = '0;
            sclk_d   = 1'b0;
        end else if (ser_f && ext_f && act_q && conv_done) begin
            act_d = 1'b0;
            err_d = 1'b1;
            bit_d = '0;
        end else if (pop) begin
            res_d    = out_if.data;
            sh_d     = out_if.data;
            loaded_d = 1'b1;
            bit_d    = '0;
        end else if (ser_f && !ext_f) begin
            if (!act_q) begin
                // start a frame once the strobes are down and no conversion runs
                if (en && loaded_q && !busy_q) begin
                    act_d = 1'b1;
                    div_d = '0;
                    ph_d  = '0;
                end
            end else if (!en) begin
                // strobes lifted: drop the frame, replay from the top later
                act_d  = 1'b0;
                sclk_d = 1'b0;
                bit_d  = '0;
                sh_d   = res_q;
            end else begin
                div_d = div_q + 4'h1;
                if (div_q == QTR_LAST) begin
                    div_d  = '0;
                    ph_d   = ph_q + 2'h1;
                    // high in quarters 1 and 2, data moves only in quarter 3
                    sclk_d = (ph_q == 2'h0) || (ph_q == 2'h1);
                    if (ph_q == 2'h3) begin
                        sh_d  = {sh_q[RES_W-2:0], 1'b0};
                        bit_d = bit_q + 4'h1;
                        if (bit_q == BIT_LAST) begin
                            act_d    = 1'b0;
                            loaded_d = 1'b0;
                        end
                    end
                end
            end
        end else if (ext_edge) begin
            act_d = 1'b1;
            sh_d  = {sh_q[RES_W-2:0], 1'b0};
            bit_d = bit_q + 4'h1;
            if (bit_q == BIT_LAST) begin
                act_d    = 1'b0;
                loaded_d = 1'b0;
            end
        end

        // pin data
        if (!ser_f) begin
            dout_d = res_q;
        end else begin
            dout_d                      = '0;
            dout_d[RES_W-1:PIN_TOP]     = res_q[RES_W-1:PIN_TOP];
            dout_d[PIN_SERIAL_RESULT_OUT]           = sh_q[RES_W-1];
            dout_d[PIN_SCLK]            = sclk_q;
            dout_d[PIN_MARK]            = (!ext_f && act_q) ^ inv_f;
            dout_d[PIN_RDERR]           = err_q;
        end
    end

    // output registers
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            res_q    <= RESULT_RST;
            sh_q     <= RESULT_RST;
            loaded_q <= 1'b0;
            act_q    <= 1'b0;
            bit_q    <= '0;
            div_q    <= '0;
            ph_q     <= '0;
            sclk_q   <= 1'b0;
            err_q    <= 1'b0;
            dout_q   <= '0;
        end else if (CE_I) begin
            res_q    <= res_d;
            sh_q     <= sh_d;
            loaded_q <= loaded_d;
            act_q    <= act_d;
            bit_q    <= bit_d;
            div_q    <= div_d;
            ph_q     <= ph_d;
            sclk_q   <= sclk_d;
            err_q    <= err_d;
            dout_q   <= dout_d;
        end
    end

    // pin enables, low while driving
    always_comb begin
        DATA_OE_N_O = '1;
        if (en) begin
            if (!ser_f) begin
                DATA_OE_N_O = '0;
            end else begin
                DATA_OE_N_O[RES_W-1:PIN_TOP] = '0;
                DATA_OE_N_O[PIN_SERIAL_RESULT_OUT]       = 1'b0;
                DATA_OE_N_O[PIN_SCLK]        = ext_f;
                DATA_OE_N_O[PIN_MARK]        = ext_f;
                DATA_OE_N_O[PIN_RDERR]       = !ext_f;
            end
        end
    end
    assign DATA_O = dout_q;

    // ---------------- checks ----------------
    busy_latch_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        $fell(busy_q) && !$past(rst_f) |-> $past(in_if.valid && in_if.ready));
    mark_active_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        ser_f && !ext_f && act_q |=> DATA_O[PIN_MARK] != $past(inv_f));
    mark_idle_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        ser_f && !act_q |=> DATA_O[PIN_MARK] == $past(inv_f));
    read_error_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        ser_f && ext_f && act_q && conv_done && !rst_f |=> err_q && !act_q ##1 !err_q);
    strobe_gate_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
        (cs_f || rd_f) |-> (DATA_OE_N_O == '1));
    sclk_gate_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        ser_f && ext_f && cs_f && act_q && !conv_done && !rst_f |=> $stable(bit_q));
    pd_inhibit_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        pd_f && state_q != ST_CONV |=> state_q != ST_CONV);
    start_now_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        state_q == ST_ACQ && cnt_q == ACQ_LAST && !cnv_f && go_ok && !rst_f
        |=> busy_q ##1 HOLD_O);
    start_edge_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        state_q == ST_ARMED && !rst_f |=> (state_q == ST_CONV) == $past(cnv_fall && go_ok));
    reset_abort_a: assert property (
        @(posedge CLK_SYS_I) disable iff (!ARST_N_I || !CE_I)
        rst_f |=> state_q == ST_ACQ && !busy_q && !act_q);
endmodule

/* adcc_host.sv */
// adcc_host: host stand-in; takes internal-clock serial words, makes the external clock
// assumes data pins come straight from adcc_top
module adcc_host (
    // clock and capture clear
    input  wire logic        clk_i,
    input  wire logic        clr_i,
    // pins seen by the host
    input  wire logic [15:0] data_i,
    input  wire logic [15:0] oe_n_i,
    // external clock request, pin, capture
    input  wire logic        ext_run_i,
    output logic             sclk_o,
    output logic [15:0]      word_o,
    output int               bits_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sclk_p = 1'b0;  // last seen clock pin
    // 80 ns clock, odd phase, still low outside frames
    initial begin
        sclk_o = 1'b0;
        #13;
        forever #40 sclk_o = ext_run_i ? ~sclk_o : 1'b0;
    end
    // shift on each rise of the device's serial clock on pin 9
    always @(posedge clk_i) begin
        sclk_p <= data_i[9];
        if (clr_i) begin
            bits_o <= 0;
        end else if (!oe_n_i[9] && data_i[9] && !sclk_p) begin
            word_o <= {word_o[14:0], data_i[8]};
            bits_o <= bits_o + 1;
        end
    end
endmodule

/* tb_top.sv */
// tb_top: self-checking bench for adcc_top
// assumes the design files and adcc_host are compiled first
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adcc_pkg::*;
    // bench-driven pins, idle at time zero except arst_n and cnv_n, which start low, and clr, which starts high
    logic clk = 1'b0, arst_n = 1'b0, rst = 1'b0, pd = 1'b0, cnv_n = 1'b0;
    logic cs_n = 1'b1, rd_n = 1'b1, ser = 1'b0, ext = 1'b0, inv = 1'b0;
    logic iref = 1'b0, rbuf = 1'b0, clr = 1'b1, ext_run = 1'b0, sclk, ce = 1'b1;
    logic [15:0] sar = 16'h0000;
    // design-driven pins
    logic hold, lowp, ref_en, buf_en, busy;
    logic [15:0] data, oe_n, word;
    int bits, err_total = 0, samples_checked = 0, flag_cnt = 0, n;
    adcc_top DUT (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .RESET_I(rst),
        .POWER_DOWN_REQ_I(pd), .CONVERT_START_N_I(cnv_n), .CS_N_I(cs_n), .RD_N_I(rd_n),
        .SERIAL_PARALLEL_SELECT_I(ser), .CLOCK_SOURCE_SELECT_I(ext),
        .FRAME_MARKER_INVERT_I(inv), .INTERNAL_REF_OFF_I(iref), .REF_BUFFER_OFF_I(rbuf),
        .SAR_RESULT_I(sar), .HOLD_O(hold), .LOW_POWER_O(lowp), .REF_EN_O(ref_en),
        .REF_BUF_EN_O(buf_en), .BUSY_O(busy), .SCLK_PIN_I(sclk), .DATA_O(data),
        .DATA_OE_N_O(oe_n));
    adcc_host HOST (.clk_i(clk), .clr_i(clr), .data_i(data), .oe_n_i(oe_n),
        .ext_run_i(ext_run), .sclk_o(sclk), .word_o(word), .bits_o(bits));
    always #5 clk = ~clk;
    // error flag pulses seen on the pin
    always @(posedge clk) if (ser && ext && !oe_n[11] && data[11] === 1'b1) flag_cnt++;
    task automatic chk_w(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_n(input int got, lo, hi);
        samples_checked++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("unexpected at %0t: count %0d", $time, got);
        end
    endtask
    // bounded wait for busy to reach a level, cycles in n
    task automatic wait_busy(input logic lv, input int lim);
        n = 0;
        while (busy !== lv && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    // one edge-started conversion; mode 1 power-down, mode 2 reset abort
    task automatic conv(input int mode);
        sar = 16'($urandom);
        repeat (200) @(negedge clk);
        chk_w({15'h0, busy}, 16'h0000);
        cnv_n = 1'b0;
        wait_busy(1'b1, 20);
        chk_n(n, 1, 8);
        chk_w({15'h0, hold}, 16'h0001);
        cnv_n = 1'b1;
        pd = (mode == 1);
        if (mode == 2) begin
            repeat (100) @(negedge clk);
            rst = 1'b1;
        end
        wait_busy(1'b0, 900);
        chk_n(n, mode == 2 ? 1 : CONV_CYC - 1, mode == 2 ? 10 : CONV_CYC);
        rst = 1'b0;
    endtask
    task automatic par_read(input logic [15:0] exp);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (6) @(negedge clk);
        chk_w(oe_n, 16'h0000);
        chk_w(data, exp);
        rd_n = 1'b1;
        repeat (6) @(negedge clk);
        chk_w(oe_n, 16'hFFFF);
        cs_n = 1'b1;
    endtask
    // internal-clock serial frame; look enables the pin checks
    task automatic sread(input logic look);
        clr = 1'b1;
        @(negedge clk) clr = 1'b0;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (20) @(negedge clk);
        if (look) begin
            chk_w({15'h0, data[10]}, {15'h0, ~inv});
            chk_w(oe_n, 16'h08FF);
            chk_w(data & 16'hF000, sar & 16'hF000);
        end
        for (int i = 0; i < 200 && bits < 16; i++) @(negedge clk);
        repeat (10) @(negedge clk);
        if (look) chk_w({15'h0, data[10]}, {15'h0, inv});
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // watchdog, several times the expected run
    initial begin
        #400000;
        err_total++;
        results();
    end
    initial begin
        void'($urandom(52161));
        sar = 16'($urandom);
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        wait_busy(1'b1, 300);
        chk_n(n, ACQ_CYC, ACQ_CYC + 15);
        cnv_n = 1'b1;
        wait_busy(1'b0, 900);
        chk_n(n, CONV_CYC - 1, CONV_CYC);
        for (int i = 0; i < 4; i++) begin
            {iref, rbuf} = 2'(i);
            repeat (6) @(negedge clk);
            chk_w({14'h0, ref_en, buf_en}, {14'h0, ~iref, ~rbuf});
        end
        // enable low freezes the filters, so the reference pin must not follow
        ce = 1'b0;
        iref = 1'b0;
        repeat (8) @(negedge clk);
        chk_w({15'h0, ref_en}, 16'h0000);
        ce = 1'b1;
        repeat (6) @(negedge clk);
        chk_w({15'h0, ref_en}, 16'h0001);
        par_read(sar);
        conv(0);
        par_read(sar);
        conv(1);
        cnv_n = 1'b0;
        repeat (50) @(negedge clk);
        chk_w({14'h0, busy, lowp}, 16'h0001);
        pd = 1'b0;
        cnv_n = 1'b1;
        conv(2);
        $display("test sequencer and parallel finished");
        ser = 1'b1;
        for (int i = 0; i < 2; i++) begin
            inv = i[0];
            sread(1'b0);
            conv(0);
            sread(1'b1);
            chk_w(word, sar);
        end
        $display("test internal serial finished");
        ext = 1'b1;
        conv(0);
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (6) @(negedge clk);
        chk_w(oe_n, 16'h06FF);
        ext_run = 1'b1;
        repeat (25) @(negedge clk);
        ext_run = 1'b0;
        conv(0);
        repeat (10) @(negedge clk);
        chk_n(flag_cnt, 1, 1);
        $display("test external serial finished");
        results();
    end
endmodule
